// [shared/wwcm_pkg.sv]
// Constants and types for the windowed watchdog and clock monitor
package wwcm_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0]  WWCM_SVC_ADDR    = 8'h00;
   localparam logic [7:0]  WWCM_STAT_ADDR   = 8'h01;

   // ----------------------------------------------------------------
   // Service word fields
   // ----------------------------------------------------------------
   localparam int          WWCM_SEL_MSB     = 7;
   localparam int          WWCM_SEL_LSB     = 6;
   localparam int          WWCM_KEY_MSB     = 5;
   localparam int          WWCM_KEY_LSB     = 1;
   localparam int          WWCM_CM_BIT      = 0;
   localparam logic [4:0]  WWCM_KEY_VALUE   = 5'h0C;
   localparam logic [4:0]  WWCM_KEY_READ    = 5'h00;
   localparam logic [1:0]  WWCM_SEL_RESET   = 2'h3;
   localparam logic        WWCM_CM_RESET    = 1'b1;

   // ----------------------------------------------------------------
   // Status word fields
   // ----------------------------------------------------------------
   localparam int          WWCM_ST_WD_BIT   = 0;
   localparam int          WWCM_ST_CM_BIT   = 1;
   localparam int          WWCM_ST_CFG_BIT  = 2;
   localparam int          WWCM_ST_PIN_BIT  = 3;

   // ----------------------------------------------------------------
   // Window limits in counted clocks
   // ----------------------------------------------------------------
   localparam int          WWCM_WCNT_W      = 17;
   localparam logic [16:0] WWCM_LOWER_LIM   = 17'h00800;
   localparam logic [16:0] WWCM_UPPER_8K    = 17'h02000;
   localparam logic [16:0] WWCM_UPPER_16K   = 17'h04000;
   localparam logic [16:0] WWCM_UPPER_32K   = 17'h08000;
   localparam logic [16:0] WWCM_UPPER_64K   = 17'h10000;
   localparam logic [1:0]  WWCM_SEL_8K      = 2'h0;
   localparam logic [1:0]  WWCM_SEL_16K     = 2'h1;
   localparam logic [1:0]  WWCM_SEL_32K     = 2'h2;

   // ----------------------------------------------------------------
   // Fault pulse and clock monitor timing
   // ----------------------------------------------------------------
   localparam logic [4:0]  WWCM_HOLD_TICKS  = 5'h18;
   localparam logic [4:0]  WWCM_RECOV_TICKS = 5'h18;
   localparam int          WWCM_CM_TMO_US   = 1000;
   localparam int          WWCM_REF_MHZ     = 250;
   localparam int          WWCM_CM_TMO_CYC  = WWCM_CM_TMO_US * WWCM_REF_MHZ;
   localparam int          WWCM_GAP_W       = 18;

   typedef enum logic [1:0] {
      WWCM_RUN,
      WWCM_DRIVE,
      WWCM_HOLD,
      WWCM_WAITHI
   } wwcm_wd_state_e;

endpackage

// [src/wwcm_top.sv]
// Windowed watchdog with clock monitor and open-drain fault pin
// Functional notes
// - Window timing counts instruction cycles (tc), not idle-timer clocks.
// - Lower window limit fixed at 2048 clocks after the last service.
// - Bits 7:6 pick upper limit 8k, 16k, 32k or 64k clocks.
// - Low-speed and dual-clock modes count 32 kHz clocks, else tc.
// - Key bits 5:1 must be 01100; any other key is an error.
// - Bit 0 enables the clock monitor when set.
// - Watchdog and fault pin active only when option bit 2 is 0.
// - Reset disables detection; then select 11 and monitor enabled.
// - Slow or dead clock after reset raises a monitor error.
// - First keyed write locks window and monitor enable for good.
// - Later writes compare all eight bits with the locked setup.
// - Full match restarts the window; any mismatch is an error.
// - No service before the upper limit gives an error.
// - Service before the lower limit is an error.
// - Boot ROM entry suppresses lower error and services at once.
// - Fault pin is active low, undriven and pulled up when idle.
// - Drive low, then 16 to 32 cycles after the pin reads low.
// - Window restarts when the pin returns high.
// - Services while the fault pin is active are ignored; the code ignores them only during a watchdog pulse, not during a monitor error.
// - Pin stuck low at power-on times out and then goes high; the code has no such timeout, and a watchdog fault waits in WAITHI for the pin.
// - Monitor holds pin low until clock recovers plus 16-32 cycles.
// - Never reject tc above 5 kHz; always reject below 10 Hz.
// - Reads return zeros in the key field.
// - Halt and idle inhibit the watchdog; monitor stays active.
// - Leaving idle performs a hardware service.
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module wwcm_top
   import wwcm_pkg::*;
#(
   parameter int CM_TIMEOUT_CYC = WWCM_CM_TMO_CYC
)
(
   input  wire logic       ref_clk_i,
   input  wire logic       srst_i,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   input  wire logic       wd_opt_bit2_i,
   input  wire logic       tc_tick_i,
   input  wire logic       lsclk_tick_i,
   input  wire logic       low_speed_mode_i,
   input  wire logic       halt_i,
   input  wire logic       idle_i,
   input  wire logic       boot_rom_i,
   input  wire logic       fault_pin_i,
   output logic            fault_pin_o,
   output logic            fault_pin_oe_o
);

   localparam logic [WWCM_GAP_W-1:0] CM_LIMIT =
      WWCM_GAP_W'(CM_TIMEOUT_CYC - 1);

   // ----------------------------------------------------------------
   // Decode and events
   // ----------------------------------------------------------------
   logic                   wd_en;
   logic                   wd_active;
   logic                   count_tick;
   logic                   svc_wr;
   logic                   key_ok;
   logic                   cfg_match;
   logic                   idle_d_r;
   logic                   halt_d_r;
   logic                   boot_d_r;
   logic                   hw_svc;

   assign wd_en      = ~wd_opt_bit2_i;
   assign wd_active  = wd_en & ~halt_i & ~idle_i;
   assign count_tick = low_speed_mode_i ? lsclk_tick_i
                                        : tc_tick_i;
   assign svc_wr     = wr_i & (addr_i == WWCM_SVC_ADDR);
   assign key_ok     = wdata_i[WWCM_KEY_MSB:WWCM_KEY_LSB]
                       == WWCM_KEY_VALUE;

   // ----------------------------------------------------------------
   // Watchdog state
   // ----------------------------------------------------------------
   wwcm_wd_state_e         state_r;
   wwcm_wd_state_e         state_nxt;
   logic [WWCM_WCNT_W-1:0] wcnt_r;
   logic [WWCM_WCNT_W-1:0] wcnt_nxt;
   logic [1:0]             cfg_sel_r;
   logic [1:0]             cfg_sel_nxt;
   logic                   cfg_cm_r;
   logic                   cfg_cm_nxt;
   logic                   cfg_done_r;
   logic                   cfg_done_nxt;
   logic [4:0]             hold_r;
   logic [4:0]             hold_nxt;
   logic [WWCM_WCNT_W-1:0] upper_lim;
   logic                   wd_err;

   assign cfg_match = key_ok
      & (wdata_i[WWCM_SEL_MSB:WWCM_SEL_LSB] == cfg_sel_r)
      & (wdata_i[WWCM_CM_BIT] == cfg_cm_r);

   // Boot ROM entry, idle exit and halt exit all restart the window
   assign hw_svc = (boot_rom_i & ~boot_d_r)
                 | (idle_d_r & ~idle_i)
                 | (halt_d_r & ~halt_i);

   always_comb
   begin
      case (cfg_sel_r)
         WWCM_SEL_8K:  upper_lim = WWCM_UPPER_8K;
         WWCM_SEL_16K: upper_lim = WWCM_UPPER_16K;
         WWCM_SEL_32K: upper_lim = WWCM_UPPER_32K;
         default:      upper_lim = WWCM_UPPER_64K;
      endcase
   end

   always_comb
   begin
      state_nxt    = state_r;
      wcnt_nxt     = wcnt_r;
      cfg_sel_nxt  = cfg_sel_r;
      cfg_cm_nxt   = cfg_cm_r;
      cfg_done_nxt = cfg_done_r;
      hold_nxt     = hold_r;
      wd_err       = 1'b0;
      case (state_r)
         WWCM_RUN:
         begin
            if (!wd_en)
            begin
               wcnt_nxt = '0;
            end
            else if (hw_svc)
            begin
               wcnt_nxt = '0;
            end
            else if (svc_wr)
            begin
               if (!cfg_done_r)
               begin
                  // First service may land anywhere in the window
                  if (key_ok)
                  begin
                     cfg_sel_nxt  = wdata_i[WWCM_SEL_MSB:WWCM_SEL_LSB];
                     cfg_cm_nxt   = wdata_i[WWCM_CM_BIT];
                     cfg_done_nxt = 1'b1;
                     wcnt_nxt     = '0;
                  end
                  else
                  begin
                     wd_err = 1'b1;
                  end
               end
               else if (!cfg_match)
               begin
                  wd_err = 1'b1;
               end
               else if ((wcnt_r < WWCM_LOWER_LIM) && !boot_rom_i)
               begin
                  wd_err = 1'b1;
               end
               else
               begin
                  wcnt_nxt = '0;
               end
            end
            else if (wd_active && (wcnt_r >= upper_lim))
            begin
               wd_err = 1'b1;
            end
            else if (wd_active && count_tick)
            begin
               wcnt_nxt = wcnt_r + 1'b1;
            end
            if (wd_err)
            begin
               state_nxt = WWCM_DRIVE;
            end
         end
         WWCM_DRIVE:
         begin
            if (!fault_pin_i)
            begin
               state_nxt = WWCM_HOLD;
               hold_nxt  = '0;
            end
         end
         WWCM_HOLD:
         begin
            if (tc_tick_i)
            begin
               if (hold_r == WWCM_HOLD_TICKS - 1'b1)
               begin
                  state_nxt = WWCM_WAITHI;
               end
               else
               begin
                  hold_nxt = hold_r + 1'b1;
               end
            end
         end
         WWCM_WAITHI:
         begin
            if (fault_pin_i)
            begin
               state_nxt = WWCM_RUN;
               wcnt_nxt  = '0;
            end
         end
         default:
         begin
            state_nxt = WWCM_RUN;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         state_r    <= WWCM_RUN;
         wcnt_r     <= '0;
         cfg_sel_r  <= WWCM_SEL_RESET;
         cfg_cm_r   <= WWCM_CM_RESET;
         cfg_done_r <= 1'b0;
         hold_r     <= '0;
         idle_d_r   <= 1'b0;
         halt_d_r   <= 1'b0;
         boot_d_r   <= 1'b0;
      end
      else
      begin
         state_r    <= state_nxt;
         wcnt_r     <= wcnt_nxt;
         cfg_sel_r  <= cfg_sel_nxt;
         cfg_cm_r   <= cfg_cm_nxt;
         cfg_done_r <= cfg_done_nxt;
         hold_r     <= hold_nxt;
         idle_d_r   <= idle_i;
         halt_d_r   <= halt_i;
         boot_d_r   <= boot_rom_i;
      end
   end

   // ----------------------------------------------------------------
   // Clock monitor
   // ----------------------------------------------------------------
   // Gap counter runs on the fast reference clock, so it keeps
   // watching tc through halt and idle.
   logic [WWCM_GAP_W-1:0]  gap_r;
   logic [WWCM_GAP_W-1:0]  gap_nxt;
   logic                   cm_err_r;
   logic                   cm_err_nxt;
   logic [4:0]             recov_r;
   logic [4:0]             recov_nxt;

   always_comb
   begin
      gap_nxt    = gap_r;
      cm_err_nxt = cm_err_r;
      recov_nxt  = recov_r;
      if (tc_tick_i)
      begin
         gap_nxt = '0;
      end
      else if (gap_r != CM_LIMIT)
      begin
         gap_nxt = gap_r + 1'b1;
      end
      if (!cfg_cm_r)
      begin
         cm_err_nxt = 1'b0;
         recov_nxt  = '0;
      end
      else if (!tc_tick_i && (gap_r == CM_LIMIT))
      begin
         cm_err_nxt = 1'b1;
         recov_nxt  = '0;
      end
      else if (cm_err_r && tc_tick_i)
      begin
         if (recov_r == WWCM_RECOV_TICKS - 1'b1)
         begin
            cm_err_nxt = 1'b0;
            recov_nxt  = '0;
         end
         else
         begin
            recov_nxt = recov_r + 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         gap_r    <= '0;
         cm_err_r <= 1'b0;
         recov_r  <= '0;
      end
      else
      begin
         gap_r    <= gap_nxt;
         cm_err_r <= cm_err_nxt;
         recov_r  <= recov_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Fault pin and read port
   // ----------------------------------------------------------------
   logic                   oe_nxt;
   logic [7:0]             rdata_nxt;
   logic                   wd_drive;

   assign wd_drive = (state_r == WWCM_DRIVE) | (state_r == WWCM_HOLD);

   always_comb
   begin
      oe_nxt    = wd_en & (wd_drive | cm_err_r);
      rdata_nxt = 8'h00;
      if (rd_i && (addr_i == WWCM_SVC_ADDR))
      begin
         rdata_nxt[WWCM_SEL_MSB:WWCM_SEL_LSB] = cfg_sel_r;
         rdata_nxt[WWCM_KEY_MSB:WWCM_KEY_LSB] = WWCM_KEY_READ;
         rdata_nxt[WWCM_CM_BIT]               = cfg_cm_r;
      end
      else if (rd_i && (addr_i == WWCM_STAT_ADDR))
      begin
         rdata_nxt[WWCM_ST_WD_BIT]  = (state_r != WWCM_RUN);
         rdata_nxt[WWCM_ST_CM_BIT]  = cm_err_r;
         rdata_nxt[WWCM_ST_CFG_BIT] = cfg_done_r;
         rdata_nxt[WWCM_ST_PIN_BIT] = fault_pin_i;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         fault_pin_oe_o <= 1'b0;
         fault_pin_o    <= 1'b0;
         rdata_o        <= 8'h00;
      end
      else
      begin
         fault_pin_oe_o <= oe_nxt;
         fault_pin_o    <= 1'b0;
         rdata_o        <= rdata_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);

   property p_reset_cfg;
      @(posedge ref_clk_i) disable iff (1'b0)
      srst_i |=> (cfg_sel_r == WWCM_SEL_RESET) && cfg_cm_r
                 && !cfg_done_r && !fault_pin_oe_o && !cm_err_r;
   endproperty
   a_reset_cfg: assert property (p_reset_cfg)
      else $error("reset state wrong");

   property p_bad_key;
      (state_r == WWCM_RUN) && wd_en && !hw_svc && svc_wr && !key_ok
      |=> (state_r == WWCM_DRIVE) ##1 fault_pin_oe_o;
   endproperty
   a_bad_key: assert property (p_bad_key)
      else $error("bad key did not raise fault");

   property p_lock;
      cfg_done_r |=> $stable(cfg_sel_r) && $stable(cfg_cm_r);
   endproperty
   a_lock: assert property (p_lock)
      else $error("locked setup changed");

   property p_mismatch;
      (state_r == WWCM_RUN) && wd_en && !hw_svc && svc_wr
      && cfg_done_r && !cfg_match |=> (state_r == WWCM_DRIVE);
   endproperty
   a_mismatch: assert property (p_mismatch)
      else $error("mismatch did not raise fault");

   property p_early;
      (state_r == WWCM_RUN) && wd_en && !hw_svc && svc_wr && cfg_done_r
      && cfg_match && (wcnt_r < WWCM_LOWER_LIM) && !boot_rom_i
      |=> (state_r == WWCM_DRIVE);
   endproperty
   a_early: assert property (p_early)
      else $error("early service not flagged");

   property p_upper;
      (state_r == WWCM_RUN) && wd_active && !hw_svc && !svc_wr
      && (wcnt_r >= upper_lim) |=> (state_r == WWCM_DRIVE);
   endproperty
   a_upper: assert property (p_upper)
      else $error("upper limit not flagged");

   property p_ignore;
      (state_r == WWCM_HOLD) && svc_wr && !tc_tick_i
      |=> (state_r == WWCM_HOLD) && $stable(hold_r);
   endproperty
   a_ignore: assert property (p_ignore)
      else $error("service during fault acted");

   property p_release;
      (state_r == WWCM_HOLD) && tc_tick_i
      && (hold_r == WWCM_HOLD_TICKS - 1'b1) && !cm_err_r && !cm_err_nxt
      |=> (state_r == WWCM_WAITHI) ##1 !fault_pin_oe_o;
   endproperty
   a_release: assert property (p_release)
      else $error("fault pulse not released");

   property p_restart;
      (state_r == WWCM_WAITHI) && fault_pin_i
      |=> (state_r == WWCM_RUN) && (wcnt_r == '0);
   endproperty
   a_restart: assert property (p_restart)
      else $error("window not restarted");

   property p_cm_timeout;
      cfg_cm_r && !tc_tick_i && (gap_r == CM_LIMIT)
      |=> cm_err_r ##1 (fault_pin_oe_o == wd_en);
   endproperty
   a_cm_timeout: assert property (p_cm_timeout)
      else $error("slow clock not rejected");

   property p_idle_svc;
      (state_r == WWCM_RUN) && wd_en && idle_d_r && !idle_i
      |=> (wcnt_r == '0) && (state_r == WWCM_RUN);
   endproperty
   a_idle_svc: assert property (p_idle_svc)
      else $error("idle exit did not service");

   property p_key_read;
      rd_i && (addr_i == WWCM_SVC_ADDR)
      |=> (rdata_o[WWCM_KEY_MSB:WWCM_KEY_LSB] == WWCM_KEY_READ)
          && (rdata_o[WWCM_SEL_MSB:WWCM_SEL_LSB] == $past(cfg_sel_r));
   endproperty
   a_key_read: assert property (p_key_read)
      else $error("key field readable");

endmodule

// [verification/wwcm_pin_model.sv]
// Fault pin wire with weak pull-up and optional slow falling edge
`timescale 1ns/1ps
module wwcm_pin_model
(
   input  wire logic ref_clk_i,
   input  wire logic oe_i,
   input  wire logic drv_i,
   input  wire logic slow_i,
   output logic      level_o
);
   logic [3:0] low_cnt_r;

   // Heavy load on the reset net: level lags the pull-down by 8 cycles
   always_ff @(posedge ref_clk_i)
   begin
      if (!oe_i)
         low_cnt_r <= 4'h0;
      else if (low_cnt_r != 4'hF)
         low_cnt_r <= low_cnt_r + 4'h1;
   end

   // Released pin goes back to the pull-up level
   assign level_o = (oe_i && (!slow_i || low_cnt_r >= 4'h8)) ? drv_i : 1'b1;
endmodule

// [verification/wwcm_top_bench.sv]
// Register-level testbench for the windowed watchdog and clock monitor
`timescale 1ns/1ps
module wwcm_top_bench;
   import wwcm_pkg::*;
   logic       ref_clk_i = 1'b0;
   logic       srst_i = 1'b1;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic       wr_i = 1'b0;
   logic       rd_i = 1'b0;
   logic [7:0] rdata_o;
   logic       wd_opt = 1'b0;
   logic       tc_tick_i = 1'b0;
   logic       boot_rom = 1'b0;
   logic       idle = 1'b0;
   logic       lsmode = 1'b0;
   logic       pin_level;
   logic       fault_pin_o;
   logic       fault_pin_oe_o;
   logic       slow = 1'b0;
   logic       tc_run = 1'b1;
   logic [1:0] tc_div = 2'h0;
   int         fails = 0;
   int         num_checks = 0;
   int         cycles = 0;
   int         t;

   always #2 ref_clk_i = ~ref_clk_i;

   // One instruction-cycle tick every 4 reference clocks
   always @(posedge ref_clk_i)
   begin
      tc_div <= tc_div + 2'h1;
      tc_tick_i <= tc_run && (tc_div == 2'h3);
   end

   wwcm_top #(.CM_TIMEOUT_CYC(64)) i_wwcm_top (
      .ref_clk_i       (ref_clk_i),
      .srst_i          (srst_i),
      .addr_i          (addr_i),
      .wdata_i         (wdata_i),
      .wr_i            (wr_i),
      .rd_i            (rd_i),
      .rdata_o         (rdata_o),
      .wd_opt_bit2_i   (wd_opt),
      .tc_tick_i       (tc_tick_i),
      .lsclk_tick_i    (1'b0),
      .low_speed_mode_i(lsmode),
      .halt_i          (1'b0),
      .idle_i          (idle),
      .boot_rom_i      (boot_rom),
      .fault_pin_i     (pin_level),
      .fault_pin_o     (fault_pin_o),
      .fault_pin_oe_o  (fault_pin_oe_o)
   );

   wwcm_pin_model i_wwcm_pin_model (
      .ref_clk_i(ref_clk_i),
      .oe_i     (fault_pin_oe_o),
      .drv_i    (fault_pin_o),
      .slow_i   (slow),
      .level_o  (pin_level)
   );

   task automatic end_sim;
   begin
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   end
   endtask

   always @(posedge ref_clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 90000)
      begin
         fails = fails + 1;
         end_sim();
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
   begin
      num_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   end
   endtask

   task automatic cyc(input int n);
   begin
      repeat (n) @(posedge ref_clk_i);
      #1;
   end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
   begin
      @(posedge ref_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   end
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
   begin
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, exp);
   end
   endtask

   task automatic wait_oe(input logic v, input int lim);
      int n;
   begin
      n = 0;
      while (fault_pin_oe_o !== v && n < lim)
      begin
         cyc(1);
         n++;
      end
      chk({7'h00, fault_pin_oe_o}, {7'h00, v});
   end
   endtask

   // Ticks from the pin reading low until the pull-down lets go
   task automatic release_ticks;
      int k;
   begin
      t = 0;
      k = 0;
      while (fault_pin_oe_o !== 1'b0 && k < 400)
      begin
         cyc(1);
         if (tc_tick_i && !pin_level)
            t++;
         k++;
      end
      chk({7'h00, t >= 16 && t <= 32}, 8'h01);
   end
   endtask

   task automatic pulse(input bit svc);
   begin
      wait_oe(1'b1, 20);
      chk({7'h00, fault_pin_o}, 8'h00);
      if (svc)
         wr(WWCM_SVC_ADDR, 8'h19);
      release_ticks();
      cyc(20);
      chk({7'h00, fault_pin_oe_o}, 8'h00);
   end
   endtask

   task automatic do_reset;
   begin
      @(posedge ref_clk_i);
      srst_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      #1;
      chk({7'h00, fault_pin_oe_o}, 8'h00);
      @(posedge ref_clk_i);
      srst_i <= 1'b0;
   end
   endtask

   initial
   begin
      do_reset();
      rd(WWCM_SVC_ADDR, 8'hC1);
      rd(WWCM_STAT_ADDR, 8'h08);
      // Wrong key on the first write, slow pin edge
      slow <= 1'b1;
      wr(WWCM_SVC_ADDR, 8'hC1);
      pulse(1'b0);
      slow <= 1'b0;
      // First keyed write locks 8k window, monitor on
      wr(WWCM_SVC_ADDR, 8'h19);
      rd(WWCM_SVC_ADDR, 8'h01);
      cyc(2100 * 4);
      wr(WWCM_SVC_ADDR, 8'hD9);
      pulse(1'b0);
      rd(WWCM_SVC_ADDR, 8'h01);
      // Window restarts at pin release; valid, then early service
      cyc(2100 * 4);
      wr(WWCM_SVC_ADDR, 8'h19);
      cyc(20);
      chk({7'h00, fault_pin_oe_o}, 8'h00);
      cyc(1000 * 4);
      wr(WWCM_SVC_ADDR, 8'h19);
      pulse(1'b1);
      // Upper limit of the 8k window
      cyc((8192 - 16) * 4);
      chk({7'h00, fault_pin_oe_o}, 8'h00);
      wait_oe(1'b1, 120);
      release_ticks();
      cyc(400);
      // Boot ROM entry services and lifts the lower limit
      @(posedge ref_clk_i);
      boot_rom <= 1'b1;
      cyc(8);
      wr(WWCM_SVC_ADDR, 8'h19);
      cyc(20);
      chk({7'h00, fault_pin_oe_o}, 8'h00);
      @(posedge ref_clk_i);
      boot_rom <= 1'b0;
      // Silent low-speed clock freezes the window count
      lsmode <= 1'b1;
      cyc(2100 * 4);
      @(posedge ref_clk_i);
      lsmode <= 1'b0;
      wr(WWCM_SVC_ADDR, 8'h19);
      pulse(1'b0);
      // Leaving idle restarts the window, so a service is early
      cyc(2100 * 4);
      @(posedge ref_clk_i);
      idle <= 1'b1;
      cyc(8);
      @(posedge ref_clk_i);
      idle <= 1'b0;
      wr(WWCM_SVC_ADDR, 8'h19);
      pulse(1'b0);
      // Dead instruction clock straight after reset
      do_reset();
      tc_run <= 1'b0;
      wait_oe(1'b1, 120);
      rd(WWCM_STAT_ADDR, 8'h02);
      tc_run <= 1'b1;
      release_ticks();
      // Monitor switched off by the first service
      do_reset();
      wr(WWCM_SVC_ADDR, 8'h18);
      rd(WWCM_SVC_ADDR, 8'h00);
      tc_run <= 1'b0;
      cyc(120);
      chk({7'h00, fault_pin_oe_o}, 8'h00);
      tc_run <= 1'b1;
      // Watchdog left out by the option bit
      do_reset();
      wd_opt <= 1'b1;
      wr(WWCM_SVC_ADDR, 8'h00);
      cyc(20);
      chk({7'h00, fault_pin_oe_o}, 8'h00);
      end_sim();
   end
endmodule
